// [shared/osc_select_pkg.sv]
// Constants, types and reset state for the system oscillator select block
package osc_select_pkg;

	// System clock 250 MHz, period 4 ns; rates held in kHz
	localparam int unsigned CLK_PERIOD_NS = 4;
	localparam int unsigned CLK_KHZ = 1000000 / CLK_PERIOD_NS;
	localparam int unsigned REF_KHZ = 500;
	localparam int unsigned LOCK_KHZ = 16000;
	localparam int unsigned ACC_W = 19;
	localparam logic [ACC_W-1:0] ACC_MOD = ACC_W'(CLK_KHZ);
	localparam logic [ACC_W-1:0] STEP_REF = ACC_W'(REF_KHZ);
	localparam logic [ACC_W-1:0] STEP_LOCK = ACC_W'(LOCK_KHZ);

	// Crystal start-up count
	localparam int unsigned OST_W = 11;
	localparam logic [OST_W-1:0] OST_OSC = 11'h400;

	// Clock source select codes
	localparam logic [2:0] SRC_LOW_GAIN = 3'h0;
	localparam logic [2:0] SRC_MED_GAIN = 3'h1;
	localparam logic [2:0] SRC_HIGH_GAIN = 3'h2;
	localparam logic [2:0] SRC_EXT_LOGIC = 3'h3;
	localparam logic [2:0] SRC_INT_PINS_FREE = 3'h4;
	localparam logic [2:0] SRC_INT_QUARTER_RATE_CLOCK_OUTPUT = 3'h5;
	localparam logic [2:0] SRC_RC_PINS_FREE = 3'h6;
	localparam logic [2:0] SRC_RC_QUARTER_RATE_CLOCK_OUTPUT = 3'h7;

	// Internal frequency select codes
	localparam logic [1:0] IFREQ_DIV1 = 2'h3;
	localparam logic [1:0] IFREQ_DIV2 = 2'h2;
	localparam logic [1:0] IFREQ_DIV4 = 2'h1;
	localparam logic [1:0] IFREQ_DIV8 = 2'h0;
	localparam logic [2:0] MASK_DIV1 = 3'h0;
	localparam logic [2:0] MASK_DIV2 = 3'h1;
	localparam logic [2:0] MASK_DIV4 = 3'h3;
	localparam logic [2:0] MASK_DIV8 = 3'h7;

	// Amplifier gain codes
	localparam logic [1:0] GAIN_OFF = 2'h0;
	localparam logic [1:0] GAIN_LOW = 2'h1;
	localparam logic [1:0] GAIN_MED = 2'h2;
	localparam logic [1:0] GAIN_HIGH = 2'h3;

	// Register byte addresses and fields
	localparam int unsigned ADDR_W = 8;
	localparam logic [ADDR_W-1:0] ADDR_CFG = 8'h00;
	localparam logic [ADDR_W-1:0] ADDR_OSC_CTL = 8'h04;
	localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h08;
	localparam int unsigned CFG_LOCK_BIT = 3;
	localparam int unsigned ST_GAIN_LSB = 1;
	localparam int unsigned ST_CNT_LSB = 16;

	// Reset values
	localparam logic [2:0] RST_SRC = SRC_INT_PINS_FREE;
	localparam logic RST_LOCK = 1'b1;
	localparam logic [1:0] RST_IFREQ = IFREQ_DIV2;

	// AHB-Lite
	localparam logic HRESP_OKAY = 1'b0;

	typedef enum logic [2:0] {
		ST_POWER_UP_DELAY_TIMER = 3'b001,
		ST_OST = 3'b010,
		ST_RUN = 3'b100
	} su_state_t;

	typedef struct packed {
		logic hsel;
		logic [31:0] haddr;
		logic [1:0] htrans;
		logic hwrite;
		logic [2:0] hsize;
		logic [31:0] hwdata;
		logic hready;
	} ahb_req_t;

	typedef struct packed {
		logic [31:0] hrdata;
		logic hreadyout;
		logic hresp;
	} ahb_rsp_t;

	typedef struct packed {
		ahb_rsp_t rsp;
		logic wr_pend;
		logic [ADDR_W-1:0] addr;
		logic [2:0] src_sel;
		logic lock;
		logic [1:0] ifreq;
		logic [ACC_W-1:0] acc;
		logic [2:0] div;
		logic [1:0] qcnt;
		logic xin_s1;
		logic xin_s2;
		logic xin_s3;
		su_state_t su;
		logic [OST_W-1:0] ost_cnt;
		logic fosc_en;
		logic core_hold;
		logic [1:0] gain;
		logic xout;
		logic xout_oe;
		logic xin_gpio;
		logic xout_gpio;
	} state_t;

	localparam state_t STATE_RST = '{
		rsp: '{hrdata: 32'h0, hreadyout: 1'b1, hresp: HRESP_OKAY},
		wr_pend: 1'b0, addr: '0, src_sel: RST_SRC, lock: RST_LOCK,
		ifreq: RST_IFREQ, acc: '0, div: '0, qcnt: '0,
		xin_s1: 1'b0, xin_s2: 1'b0, xin_s3: 1'b0, su: ST_POWER_UP_DELAY_TIMER,
		ost_cnt: '0, fosc_en: 1'b0, core_hold: 1'b1, gain: GAIN_OFF,
		xout: 1'b0, xout_oe: 1'b0, xin_gpio: 1'b0, xout_gpio: 1'b0
	};

endpackage

// [rtl/osc_select.sv]
// System oscillator select: source choice, postscaler, start-up hold, pins
//
// Design decisions made here: the register offsets and the AHB-Lite slave port.
module osc_select (
	// Clock and reset
	input wire logic clk_sys_i,
	input wire logic rst_i,
	// Register bus
	input wire osc_select_pkg::ahb_req_t ahb_i,
	output osc_select_pkg::ahb_rsp_t ahb_o,
	// Power and sleep events from the core
	input wire logic power_up_delay_timer_done_i,
	input wire logic wake_i,
	// Oscillator pins
	input wire logic crystal_in_pin_i,
	output logic crystal_out_pin_o,
	output logic crystal_out_pin_oe_o,
	output logic crystal_in_gpio_o,
	output logic crystal_out_gpio_o,
	// Clocking results
	output logic fosc_en_o,
	output logic core_hold_o,
	output logic [1:0] amp_gain_o
);

	osc_select_pkg::state_t s_q;
	osc_select_pkg::state_t s_d;
	logic take;
	logic xin_rise;
	logic is_int;
	logic is_xtal;
	logic clk_out_mode;
	logic src_tick;
	logic int_tick;
	logic tick;
	logic [2:0] div_mask;
	logic [osc_select_pkg::ACC_W-1:0] step;
	logic [osc_select_pkg::ACC_W-1:0] acc_sum;
	logic [31:0] rd;

	////////////////////////////////////////////////////////////////////////
	// Next state
	always_comb begin
		s_d = s_q;
		rd = 32'h0;

		// In-pin synchroniser; only the second and third stages are looked at
		s_d.xin_s1 = crystal_in_pin_i;
		s_d.xin_s2 = s_q.xin_s1;
		s_d.xin_s3 = s_q.xin_s2;
		xin_rise = s_q.xin_s2 & ~s_q.xin_s3;

		// Data phase of a write; unmapped addresses are ignored
		if (s_q.wr_pend) begin
			if (s_q.addr == osc_select_pkg::ADDR_CFG) begin
				s_d.src_sel = ahb_i.hwdata[2:0];
				s_d.lock = ahb_i.hwdata[osc_select_pkg::CFG_LOCK_BIT];
			end else if (s_q.addr == osc_select_pkg::ADDR_OSC_CTL) begin
				s_d.ifreq = ahb_i.hwdata[1:0];
			end
		end

		// Address phase
		take = ahb_i.hsel & ahb_i.hready & ahb_i.htrans[1];
		s_d.wr_pend = take & ahb_i.hwrite;
		if (take) begin
			s_d.addr = ahb_i.haddr[osc_select_pkg::ADDR_W-1:0];
		end

		// Mode decode from the source select field
		is_int = (s_q.src_sel == osc_select_pkg::SRC_INT_PINS_FREE)
			| (s_q.src_sel == osc_select_pkg::SRC_INT_QUARTER_RATE_CLOCK_OUTPUT);
		is_xtal = (s_q.src_sel == osc_select_pkg::SRC_LOW_GAIN)
			| (s_q.src_sel == osc_select_pkg::SRC_MED_GAIN)
			| (s_q.src_sel == osc_select_pkg::SRC_HIGH_GAIN);
		clk_out_mode = (s_q.src_sel == osc_select_pkg::SRC_INT_QUARTER_RATE_CLOCK_OUTPUT)
			| (s_q.src_sel == osc_select_pkg::SRC_RC_QUARTER_RATE_CLOCK_OUTPUT);

		// Internal source: fractional accumulator gives exact average rate
		step = s_q.lock ? osc_select_pkg::STEP_LOCK : osc_select_pkg::STEP_REF;
		acc_sum = s_q.acc + step;
		src_tick = (acc_sum >= osc_select_pkg::ACC_MOD);
		s_d.acc = src_tick ? (acc_sum - osc_select_pkg::ACC_MOD) : acc_sum;

		// Postscaler; counter keeps running so a new setting needs no restart
		case (s_q.ifreq)
			osc_select_pkg::IFREQ_DIV1: div_mask = osc_select_pkg::MASK_DIV1;
			osc_select_pkg::IFREQ_DIV2: div_mask = osc_select_pkg::MASK_DIV2;
			osc_select_pkg::IFREQ_DIV4: div_mask = osc_select_pkg::MASK_DIV4;
			default: div_mask = osc_select_pkg::MASK_DIV8;
		endcase
		if (src_tick) begin
			s_d.div = s_q.div + 3'h1;
		end
		int_tick = src_tick & ((s_q.div & div_mask) == div_mask);

		// External sources tick on in-pin edges; no edge means no progress
		tick = is_int ? int_tick : xin_rise;
		s_d.fosc_en = tick;

		// Quarter-rate clock on the out-pin
		if (tick) begin
			s_d.qcnt = s_q.qcnt + 2'h1;
		end
		s_d.xout = clk_out_mode & s_d.qcnt[1];
		s_d.xout_oe = clk_out_mode;
		s_d.xin_gpio = is_int;
		s_d.xout_gpio = (s_q.src_sel == osc_select_pkg::SRC_INT_PINS_FREE)
			| (s_q.src_sel == osc_select_pkg::SRC_EXT_LOGIC)
			| (s_q.src_sel == osc_select_pkg::SRC_RC_PINS_FREE);

		// Amplifier gain
		case (s_q.src_sel)
			osc_select_pkg::SRC_LOW_GAIN: s_d.gain = osc_select_pkg::GAIN_LOW;
			osc_select_pkg::SRC_MED_GAIN: s_d.gain = osc_select_pkg::GAIN_MED;
			osc_select_pkg::SRC_HIGH_GAIN: s_d.gain = osc_select_pkg::GAIN_HIGH;
			default: s_d.gain = osc_select_pkg::GAIN_OFF;
		endcase

		// Start-up sequence
		case (s_q.su)
			osc_select_pkg::ST_POWER_UP_DELAY_TIMER: begin
				s_d.ost_cnt = '0;
				if (power_up_delay_timer_done_i) begin
					s_d.su = is_xtal ? osc_select_pkg::ST_OST
						: osc_select_pkg::ST_RUN;
				end
			end
			osc_select_pkg::ST_OST: begin
				if (xin_rise) begin
					s_d.ost_cnt = s_q.ost_cnt + 11'h1;
				end
				if (s_d.ost_cnt == osc_select_pkg::OST_OSC) begin
					s_d.su = osc_select_pkg::ST_RUN;
				end
			end
			osc_select_pkg::ST_RUN: begin
				// Wake restarts the count only for crystal sources
				if (wake_i & is_xtal) begin
					s_d.ost_cnt = '0;
					s_d.su = osc_select_pkg::ST_OST;
				end
			end
			default: s_d.su = osc_select_pkg::ST_POWER_UP_DELAY_TIMER;
		endcase
		s_d.core_hold = (s_d.su != osc_select_pkg::ST_RUN);

		// Config read data from next values so a write is seen by a read right after; status reads current values
		if (take & ~ahb_i.hwrite) begin
			if (s_d.addr == osc_select_pkg::ADDR_CFG) begin
				rd[2:0] = s_d.src_sel;
				rd[osc_select_pkg::CFG_LOCK_BIT] = s_d.lock;
			end else if (s_d.addr == osc_select_pkg::ADDR_OSC_CTL) begin
				rd[1:0] = s_d.ifreq;
			end else if (s_d.addr == osc_select_pkg::ADDR_STATUS) begin
				rd[0] = s_q.core_hold;
				rd[osc_select_pkg::ST_GAIN_LSB +: 2] = s_q.gain;
				rd[osc_select_pkg::ST_CNT_LSB +: osc_select_pkg::OST_W] = s_q.ost_cnt;
			end
		end
		s_d.rsp.hrdata = rd;
		s_d.rsp.hreadyout = 1'b1;
		s_d.rsp.hresp = osc_select_pkg::HRESP_OKAY;
	end

	////////////////////////////////////////////////////////////////////////
	// State register; reset reloads the frequency select default
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			s_q <= osc_select_pkg::STATE_RST;
		end else begin
			s_q <= s_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs straight from the state register
	assign ahb_o = s_q.rsp;
	assign fosc_en_o = s_q.fosc_en;
	assign core_hold_o = s_q.core_hold;
	assign amp_gain_o = s_q.gain;
	assign crystal_out_pin_o = s_q.xout;
	assign crystal_out_pin_oe_o = s_q.xout_oe;
	assign crystal_in_gpio_o = s_q.xin_gpio;
	assign crystal_out_gpio_o = s_q.xout_gpio;

endmodule // osc_select

// [sim/xtal_model.sv]
// Behavioural crystal or logic-level clock source on the in-pin
module xtal_model (
	// Control from the bench
	input wire logic run_i,
	// Oscillator in-pin
	output logic pin_o
);
	timeunit 1ns;
	timeprecision 1ns;
	// Odd-ns toggles stay clear of bench clock edges; a stopped source holds
	initial begin
		pin_o = 1'b0;
		#1;
		forever begin
			#8;
			if (run_i)
				pin_o = ~pin_o;
		end
	end
endmodule // xtal_model

// [sim/osc_select_monitor.sv]
// Assertion checker for the oscillator select block
module osc_select_monitor (
	// Clock and reset
	input wire logic clk_sys_i,
	input wire logic rst_i,
	// Register bus
	input wire osc_select_pkg::ahb_req_t ahb_i,
	input wire osc_select_pkg::ahb_rsp_t ahb_o,
	// Events and pins
	input wire logic power_up_delay_timer_done_i,
	input wire logic wake_i,
	input wire logic crystal_in_pin_i,
	input wire logic crystal_out_pin_o,
	input wire logic crystal_out_pin_oe_o,
	input wire logic crystal_in_gpio_o,
	input wire logic crystal_out_gpio_o,
	input wire logic fosc_en_o,
	input wire logic core_hold_o,
	input wire logic [1:0] amp_gain_o
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (rst_i);
	logic pin_q;
	logic [11:0] edge_q;
	////////////////////////////////////////////////////////////
	// In-pin rises while held; leads the synchroniser, hence the slack
	always_ff @(posedge clk_sys_i) begin
		pin_q <= crystal_in_pin_i;
		if (rst_i || !core_hold_o)
			edge_q <= 12'h000;
		else if (crystal_in_pin_i && !pin_q && edge_q != 12'hfff)
			edge_q <= edge_q + 12'h001;
	end
	sequence s_xtal_wake;
		wake_i && amp_gain_o != osc_select_pkg::GAIN_OFF && !core_hold_o;
	endsequence
	////////////////////////////////////////////////////////////
	a_pulse_single: assert property (fosc_en_o |=> !fosc_en_o)
		else $error("clock enable wider than one cycle");
	// Either clock-out mode drives the out-pin, so the out-pin is not GPIO and the amplifier is off
	a_quarter_rate_clock_output_pins: assert property (crystal_out_pin_oe_o
		|-> !crystal_out_gpio_o && amp_gain_o == osc_select_pkg::GAIN_OFF)
		else $error("clock output mode pins wrong");
	a_out_quiet: assert property (!crystal_out_pin_oe_o |-> !crystal_out_pin_o)
		else $error("out-pin toggles while not driven");
	a_gain_pins: assert property (amp_gain_o != osc_select_pkg::GAIN_OFF
		|-> !crystal_in_gpio_o && !crystal_out_gpio_o && !crystal_out_pin_oe_o)
		else $error("crystal mode frees a pin");
	a_wake_restart: assert property (s_xtal_wake |=> core_hold_o)
		else $error("wake did not restart the count");
	a_wake_ignored: assert property (wake_i && amp_gain_o == osc_select_pkg::GAIN_OFF
		&& !core_hold_o |=> !core_hold_o)
		else $error("wake held a non-crystal core");
	a_ext_no_hold: assert property (power_up_delay_timer_done_i && core_hold_o
		&& amp_gain_o == osc_select_pkg::GAIN_OFF |-> ##[1:3] !core_hold_o)
		else $error("non-crystal mode kept the core held");
	a_count_full: assert property ($fell(core_hold_o)
		&& amp_gain_o != osc_select_pkg::GAIN_OFF |-> edge_q >= 12'h3fe && edge_q <= 12'h406)
		else $error("start-up count length wrong");
endmodule // osc_select_monitor

bind osc_select osc_select_monitor MON (.*);

// [sim/system_oscillator_select_test.sv]
// Self-checking bench for the oscillator select block
module system_oscillator_select_test;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_sys_i = 1'b0;
	logic rst_i = 1'b1;
	logic power_up_delay_timer_done_i = 1'b1;
	logic wake_i = 1'b0;
	logic xtal_run = 1'b0;
	logic pin, out_pin, out_oe, in_gpio, out_gpio, fosc_en, hold, pv;
	logic [1:0] gain;
	logic [31:0] rd;
	osc_select_pkg::ahb_req_t bus_q = '0;
	osc_select_pkg::ahb_rsp_t rsp;
	int miscompares = 0;
	int samples_checked = 0;
	int cyc = 0;
	int nf, no, e;
	// Expected {gain, in free, out free, out driven} for sources 0 to 7
	logic [4:0] pins_tab [8] = '{5'h08, 5'h10, 5'h18, 5'h02, 5'h06, 5'h05, 5'h02, 5'h01};
	// Bus hready is the slave's own hreadyout
	osc_select DUT (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
		.ahb_i({bus_q[$bits(bus_q)-1:1], rsp.hreadyout}), .ahb_o(rsp),
		.power_up_delay_timer_done_i(power_up_delay_timer_done_i), .wake_i(wake_i), .crystal_in_pin_i(pin),
		.crystal_out_pin_o(out_pin), .crystal_out_pin_oe_o(out_oe),
		.crystal_in_gpio_o(in_gpio), .crystal_out_gpio_o(out_gpio),
		.fosc_en_o(fosc_en), .core_hold_o(hold), .amp_gain_o(gain));
	xtal_model XTAL (.run_i(xtal_run), .pin_o(pin));
	initial forever #2 clk_sys_i = ~clk_sys_i;
	////////////////////////////////////////////////////////////
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	// Hang guard, well above the expected run
	always @(posedge clk_sys_i) begin
		cyc <= cyc + 1;
		if (cyc == 80000) begin
			miscompares++;
			report_and_stop();
		end
	end
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			miscompares++;
			$display("BAD at %0t: saw %h wanted %h", $time, seen, exp);
		end
	endtask
	task automatic near(input int v, input int lo, input int hi);
		check((v >= lo && v <= hi) ? 32'h1 : 32'h0, 32'h1);
	endtask
	// Single word transfer; waits on hready in both phases, hang guard ends a stall
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		bus_q.hsel <= 1'b1;
		bus_q.haddr <= {24'h000000, a};
		bus_q.htrans <= 2'h2;
		bus_q.hwrite <= wr;
		bus_q.hsize <= 3'h2;
		for (int p = 0; p < 2; p++) begin
			@(posedge clk_sys_i);
			while (rsp.hreadyout !== 1'b1) begin
				@(posedge clk_sys_i);
			end
			if (p == 0) begin
				bus_q.hsel <= 1'b0;
				bus_q.htrans <= 2'h0;
				bus_q.hwdata <= wd;
			end
		end
		rd = rsp.hrdata;
	endtask
	// Counts clock enables and out-pin rises over n cycles
	task automatic count(input int n);
		nf = 0;
		no = 0;
		pv = out_pin;
		repeat (n) begin
			@(posedge clk_sys_i);
			nf += (fosc_en === 1'b1);
			no += (out_pin === 1'b1 && pv === 1'b0);
			pv = out_pin;
		end
	endtask
	////////////////////////////////////////////////////////////
	initial begin
		repeat (3) @(posedge clk_sys_i);
		rst_i <= 1'b0;
		@(posedge clk_sys_i);
		bus(1'b0, osc_select_pkg::ADDR_CFG, 32'h0);
		check(rd, 32'h0000000c);
		check({31'h0, rsp.hresp}, 32'h0);
		bus(1'b0, osc_select_pkg::ADDR_OSC_CTL, 32'h0);
		check(rd, 32'h00000002);
		bus(1'b0, 8'h0c, 32'h0);
		check(rd, 32'h00000000);
		check({31'h0, hold}, 32'h0);
		for (int s = 0; s < 8; s++) begin
			bus(1'b1, osc_select_pkg::ADDR_CFG, 32'h8 | s);
			repeat (2) @(posedge clk_sys_i);
			check({gain, in_gpio, out_gpio, out_oe}, pins_tab[s]);
		end
		// Both rate sets through all four postscaler codes
		for (int k = 0; k < 8; k++) begin
			bus(1'b1, osc_select_pkg::ADDR_CFG, (k < 4) ? 32'hd : 32'h5);
			bus(1'b1, osc_select_pkg::ADDR_OSC_CTL, 32'(3 - k % 4));
			count(4000);
			e = ((k < 4) ? 256 : 8) >> (k % 4);
			near(nf, e - 1, e + 1);
			near(no, e / 4 - 1, e / 4 + 1);
		end
		bus(1'b1, osc_select_pkg::ADDR_CFG, 32'h8);
		xtal_run <= 1'b1;
		// Gain output follows the new source one edge later; wake after that
		@(posedge clk_sys_i);
		wake_i <= 1'b1;
		@(posedge clk_sys_i);
		wake_i <= 1'b0;
		@(posedge clk_sys_i);
		check({31'h0, hold}, 32'h1);
		e = 0;
		pv = pin;
		for (int k = 0; k < 6000 && hold !== 1'b0; k++) begin
			@(posedge clk_sys_i);
			e += (pin === 1'b1 && pv === 1'b0);
			pv = pin;
		end
		near(e, 1022, 1030);
		// Status: released, low gain, full start-up count
		bus(1'b0, osc_select_pkg::ADDR_STATUS, 32'h0);
		check(rd, 32'h04000002);
		bus(1'b1, osc_select_pkg::ADDR_CFG, 32'hb);
		@(posedge clk_sys_i);
		wake_i <= 1'b1;
		@(posedge clk_sys_i);
		wake_i <= 1'b0;
		count(400);
		check({31'h0, hold}, 32'h0);
		near(nf, 98, 102);
		xtal_run <= 1'b0;
		count(400);
		near(nf, 0, 1);
		xtal_run <= 1'b1;
		count(400);
		near(nf, 98, 102);
		// Mid-run reset with the power-up delay still running
		power_up_delay_timer_done_i <= 1'b0;
		rst_i <= 1'b1;
		repeat (3) @(posedge clk_sys_i);
		rst_i <= 1'b0;
		repeat (4) @(posedge clk_sys_i);
		check({31'h0, hold}, 32'h1);
		power_up_delay_timer_done_i <= 1'b1;
		repeat (2) @(posedge clk_sys_i);
		check({31'h0, hold}, 32'h0);
		bus(1'b0, osc_select_pkg::ADDR_OSC_CTL, 32'h0);
		check(rd, 32'h00000002);
		report_and_stop();
	end
endmodule // system_oscillator_select_test
